// *** rtl/proc_ctrl_regs_pkg.sv ***
package proc_ctrl_regs_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [15:0] REG_COMMAND_TRIGGER   = 16'h0FA0;
  localparam logic [15:0] REG_FIRMWARE_VERSION  = 16'h0FA1;
  localparam logic [15:0] REG_HARDWARE_OPTION   = 16'h0FA2;
  localparam logic [15:0] REG_CONTROLLER_STATE  = 16'h0FA3;
  localparam logic [15:0] REG_ALARM_STATE       = 16'h0FA4;
  localparam logic [15:0] REG_ERROR_STATE       = 16'h0FA5;
  localparam logic [15:0] REG_MEASURED_MAIN     = 16'h0FA6;
  localparam logic [15:0] REG_AUXILIARY_INPUT   = 16'h0FA7;
  localparam logic [15:0] REG_ACTIVE_SETPOINT   = 16'h0FA8;
  localparam logic [15:0] REG_LOOP_ONE_OUTPUT   = 16'h0FA9;
  localparam logic [15:0] REG_LOOP_TWO_OUTPUT   = 16'h0FAA;
  localparam logic [15:0] REG_TIMER_SECONDS     = 16'h0FAB;
  localparam logic [15:0] REG_HEATER_CURRENT_ON = 16'h0FAC;
  localparam logic [15:0] REG_HEATER_CURRENT_OFF = 16'h0FAD;
  localparam logic [15:0] REG_DISPLAY_UNIT      = 16'h0FAE;
  localparam logic [15:0] REG_MAIN_INPUT_KIND   = 16'h0FAF;

  // ---------------------------------------------------------------------------
  // Float areas
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FLOAT_PAIR_LO   = 16'h1B58;
  localparam logic [15:0] FLOAT_PAIR_HI   = 16'h1BBB;
  localparam logic [15:0] FLOAT_WIDE_LO   = 16'h1D4C;
  localparam logic [15:0] FLOAT_WIDE_HI   = 16'h1DAF;
  localparam int          FLOAT_IDX_W     = 6;

  // ---------------------------------------------------------------------------
  // Write value limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LOOP_OUTPUT_MAX = 16'h03E8;
  localparam logic [15:0] DISPLAY_UNIT_MAX = 16'h0002;
  localparam logic [15:0] INPUT_KIND_MAX  = 16'h000E;
  localparam logic [15:0] CMD_CODE_MIN    = 16'h0001;
  localparam logic [15:0] CMD_CODE_MAX    = 16'h0006;

  // ---------------------------------------------------------------------------
  // Reset values of writable registers
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LOOP_OUTPUT_RST  = 16'h0000;
  localparam logic [15:0] DISPLAY_UNIT_RST = 16'h0000;
  localparam logic [15:0] INPUT_KIND_RST   = 16'h0000;
  localparam logic [15:0] WORD_ZERO        = 16'h0000;

  // ---------------------------------------------------------------------------
  // Version code field layout
  // ---------------------------------------------------------------------------
  localparam int OUT1_TYPE_LSB = 0;
  localparam int OUT2_TYPE_LSB = 3;
  localparam int OPTION_LSB    = 6;
  localparam int TYPE_FIELD_W  = 3;

  // ---------------------------------------------------------------------------
  // Exception codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_BAD_ADDR  = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CMD_AUTO          = 16'h0001;
  localparam logic [15:0] CMD_MANUAL        = 16'h0002;
  localparam logic [15:0] CMD_AUTOTUNE      = 16'h0003;
  localparam logic [15:0] CMD_CLEAR_ALARMS  = 16'h0004;
  localparam logic [15:0] CMD_FACTORY_SETUP = 16'h0005;
  localparam logic [15:0] CMD_FACTORY_PROGS = 16'h0006;

  // Request sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ANSWER
  } access_state_t;

  // Inclusive address window test
  function automatic logic addr_in(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    addr_in = (a >= lo) && (a <= hi);
  endfunction

endpackage

// *** rtl/command_pulser.sv ***
`timescale 1ns/100ps
`default_nettype none
module command_pulser
  import proc_ctrl_regs_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_cmd_stb,
  input  wire logic [15:0] i_cmd_code,
  output logic             o_go_auto,
  output logic             o_go_manual,
  output logic             o_start_autotune,
  output logic             o_clear_alarms,
  output logic             o_restore_setup,
  output logic             o_restore_programs
);

  // ---------------------------------------------------------------------------
  // One-cycle action pulses per accepted command
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_go_auto          <= 1'b0;
      o_go_manual        <= 1'b0;
      o_start_autotune   <= 1'b0;
      o_clear_alarms     <= 1'b0;
      o_restore_setup    <= 1'b0;
      o_restore_programs <= 1'b0;
    end else begin
      o_go_auto          <= i_cmd_stb && (i_cmd_code == CMD_AUTO);
      o_go_manual        <= i_cmd_stb && (i_cmd_code == CMD_MANUAL);
      o_start_autotune   <= i_cmd_stb && (i_cmd_code == CMD_AUTOTUNE);
      o_clear_alarms     <= i_cmd_stb && (i_cmd_code == CMD_CLEAR_ALARMS);
      o_restore_setup    <= i_cmd_stb && (i_cmd_code == CMD_FACTORY_SETUP);
      o_restore_programs <= i_cmd_stb && (i_cmd_code == CMD_FACTORY_PROGS);
    end
  end

endmodule // command_pulser
`default_nettype wire

// *** rtl/process_controller_register_map.sv ***
`timescale 1ns/100ps
`default_nettype none
module process_controller_register_map
  import proc_ctrl_regs_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset,
  // Decoded register request from the frame layer
  input  wire logic                   i_req_valid,
  output logic                        o_req_ready,
  input  wire logic                   i_req_fault,
  input  wire logic                   i_req_write,
  input  wire logic [15:0]            i_req_addr,
  input  wire logic [15:0]            i_req_wdata,
  // Answer to the frame layer
  output logic                        o_rsp_valid,
  output logic                        o_rsp_exc,
  output logic [7:0]                  o_rsp_exc_code,
  output logic [15:0]                 o_rsp_data,
  // Float value source
  output logic [FLOAT_IDX_W-1:0]      o_float_idx,
  input  wire logic [31:0]            i_float_value,
  // Controller state shown to the master
  input  wire logic [15:0]            i_firmware_version,
  input  wire logic [2:0]             i_out1_type,
  input  wire logic [2:0]             i_out2_type,
  input  wire logic [2:0]             i_option_kind,
  input  wire logic [15:0]            i_controller_state,
  input  wire logic [15:0]            i_alarm_state,
  input  wire logic [15:0]            i_error_state,
  input  wire logic [15:0]            i_measured_process_value,
  input  wire logic [15:0]            i_auxiliary_input,
  input  wire logic [15:0]            i_setpoint_value,
  input  wire logic [15:0]            i_timer_seconds,
  input  wire logic [15:0]            i_heater_current_on,
  input  wire logic [15:0]            i_heater_current_off,
  // Settings steering the controller
  output logic [15:0]                 o_loop_one_output,
  output logic [15:0]                 o_loop_two_output,
  output logic [15:0]                 o_display_unit,
  output logic [15:0]                 o_main_input_kind,
  // Command actions
  output logic                        o_go_auto,
  output logic                        o_go_manual,
  output logic                        o_start_autotune,
  output logic                        o_clear_alarms,
  output logic                        o_restore_setup,
  output logic                        o_restore_programs
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  access_state_t          state_r;
  access_state_t          state_nxt;
  logic                   write_r;
  logic [15:0]            addr_r;
  logic [15:0]            wdata_r;
  logic [15:0]            loop_one_r;
  logic [15:0]            loop_two_r;
  logic [15:0]            unit_r;
  logic [15:0]            input_kind_r;
  logic                   rsp_exc_r;
  logic [7:0]             rsp_code_r;
  logic [15:0]            rsp_data_r;
  logic [FLOAT_IDX_W-1:0] float_idx_r;
  logic [FLOAT_IDX_W-1:0] float_idx_nxt;
  logic                   take_req;
  logic                   in_pair_area;
  logic                   in_wide_area;
  logic [15:0]            area_offset;
  logic                   rd_hi_word;
  logic [15:0]            version_code;
  logic [15:0]            rd_data;
  logic [7:0]             exc_code;
  logic                   wr_loop_one;
  logic                   wr_loop_two;
  logic                   wr_unit;
  logic                   wr_input_kind;
  logic                   cmd_stb;

  // ---------------------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------------------
  // One request in flight; answer shown in ANSWER state only
  assign o_req_ready = (state_r == ST_IDLE);
  assign o_rsp_valid = (state_r == ST_ANSWER);
  assign take_req    = i_req_valid && o_req_ready && !i_req_fault;

  // Outputs from flip-flops
  assign o_rsp_exc         = rsp_exc_r;
  assign o_rsp_exc_code    = rsp_code_r;
  assign o_rsp_data        = rsp_data_r;
  assign o_float_idx       = float_idx_r;
  assign o_loop_one_output = loop_one_r;
  assign o_loop_two_output = loop_two_r;
  assign o_display_unit    = unit_r;
  assign o_main_input_kind = input_kind_r;

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Faulty requests are dropped in IDLE and never answered
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:   if (take_req) state_nxt = ST_FETCH;
      ST_FETCH:  state_nxt = ST_ANSWER;
      ST_ANSWER: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------------------
  // Float index is chosen at capture so the source has a full cycle
  always_comb begin
    float_idx_nxt = '0;
    if (addr_in(i_req_addr, FLOAT_PAIR_LO, FLOAT_PAIR_HI)) begin
      float_idx_nxt = FLOAT_IDX_W'((i_req_addr - FLOAT_PAIR_LO) >> 1);
    end else if (addr_in(i_req_addr, FLOAT_WIDE_LO, FLOAT_WIDE_HI)) begin
      float_idx_nxt = FLOAT_IDX_W'((i_req_addr - FLOAT_WIDE_LO) >> 1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      write_r     <= 1'b0;
      addr_r      <= WORD_ZERO;
      wdata_r     <= WORD_ZERO;
      float_idx_r <= '0;
    end else if (take_req) begin
      write_r     <= i_req_write;
      addr_r      <= i_req_addr;
      wdata_r     <= i_req_wdata;
      float_idx_r <= float_idx_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Area decode
  // ---------------------------------------------------------------------------
  assign in_pair_area = addr_in(addr_r, FLOAT_PAIR_LO, FLOAT_PAIR_HI);
  assign in_wide_area = addr_in(addr_r, FLOAT_WIDE_LO, FLOAT_WIDE_HI);
  // Even position carries the upper half of the float
  assign area_offset  = in_pair_area ? (addr_r - FLOAT_PAIR_LO) : (addr_r - FLOAT_WIDE_LO);
  assign rd_hi_word   = !area_offset[0];

  // Version code word assembled from fitted hardware
  always_comb begin
    version_code = WORD_ZERO;
    version_code[OUT1_TYPE_LSB +: TYPE_FIELD_W] = i_out1_type;
    version_code[OUT2_TYPE_LSB +: TYPE_FIELD_W] = i_out2_type;
    version_code[OPTION_LSB +: TYPE_FIELD_W]    = i_option_kind;
  end

  // ---------------------------------------------------------------------------
  // Read data, write enables and exception choice
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_data       = WORD_ZERO;
    exc_code      = EXC_NONE;
    wr_loop_one   = 1'b0;
    wr_loop_two   = 1'b0;
    wr_unit       = 1'b0;
    wr_input_kind = 1'b0;
    cmd_stb       = 1'b0;
    if (in_pair_area || in_wide_area) begin
      if (write_r) begin
        exc_code = EXC_BAD_VALUE;
      end else begin
        rd_data = rd_hi_word ? i_float_value[31:16] : i_float_value[15:0];
      end
    end else begin
      unique case (addr_r)
        REG_COMMAND_TRIGGER: begin
          if (write_r) begin
            if (addr_in(wdata_r, CMD_CODE_MIN, CMD_CODE_MAX)) begin
              cmd_stb = 1'b1;
            end else begin
              exc_code = EXC_BAD_VALUE;
            end
          end
        end
        REG_FIRMWARE_VERSION:   rd_data = i_firmware_version;
        REG_HARDWARE_OPTION:    rd_data = version_code;
        REG_CONTROLLER_STATE:   rd_data = i_controller_state;
        REG_ALARM_STATE:        rd_data = i_alarm_state;
        REG_ERROR_STATE:        rd_data = i_error_state;
        REG_MEASURED_MAIN:      rd_data = i_measured_process_value;
        REG_AUXILIARY_INPUT:    rd_data = i_auxiliary_input;
        REG_ACTIVE_SETPOINT:    rd_data = i_setpoint_value;
        REG_TIMER_SECONDS:      rd_data = i_timer_seconds;
        REG_HEATER_CURRENT_ON:  rd_data = i_heater_current_on;
        REG_HEATER_CURRENT_OFF: rd_data = i_heater_current_off;
        REG_LOOP_ONE_OUTPUT: begin
          rd_data = loop_one_r;
          if (write_r) begin
            if (wdata_r <= LOOP_OUTPUT_MAX) wr_loop_one = 1'b1;
            else exc_code = EXC_BAD_VALUE;
          end
        end
        REG_LOOP_TWO_OUTPUT: begin
          rd_data = loop_two_r;
          if (write_r) begin
            if (wdata_r <= LOOP_OUTPUT_MAX) wr_loop_two = 1'b1;
            else exc_code = EXC_BAD_VALUE;
          end
        end
        REG_DISPLAY_UNIT: begin
          rd_data = unit_r;
          if (write_r) begin
            if (wdata_r <= DISPLAY_UNIT_MAX) wr_unit = 1'b1;
            else exc_code = EXC_BAD_VALUE;
          end
        end
        REG_MAIN_INPUT_KIND: begin
          rd_data = input_kind_r;
          if (write_r) begin
            if (wdata_r <= INPUT_KIND_MAX) wr_input_kind = 1'b1;
            else exc_code = EXC_BAD_VALUE;
          end
        end
        default: exc_code = EXC_BAD_ADDR;
      endcase
      // Read-only registers refuse writes
      if (write_r && (exc_code == EXC_NONE) && !cmd_stb && !wr_loop_one && !wr_loop_two
          && !wr_unit && !wr_input_kind) begin
        exc_code = EXC_BAD_VALUE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Writable settings
  // ---------------------------------------------------------------------------
  // Loop outputs, tenths of a percent
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_one_r <= LOOP_OUTPUT_RST;
      loop_two_r <= LOOP_OUTPUT_RST;
    end else if (state_r == ST_FETCH) begin
      if (wr_loop_one) loop_one_r <= wdata_r;
      if (wr_loop_two) loop_two_r <= wdata_r;
    end
  end

  // Display unit and main input kind
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      unit_r       <= DISPLAY_UNIT_RST;
      input_kind_r <= INPUT_KIND_RST;
    end else if (state_r == ST_FETCH) begin
      if (wr_unit) unit_r <= wdata_r;
      if (wr_input_kind) input_kind_r <= wdata_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Answer registers
  // ---------------------------------------------------------------------------
  // Data is cleared on any exception so nothing stale leaks out
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rsp_exc_r  <= 1'b0;
      rsp_code_r <= EXC_NONE;
      rsp_data_r <= WORD_ZERO;
    end else if (state_r == ST_FETCH) begin
      rsp_exc_r  <= (exc_code != EXC_NONE);
      rsp_code_r <= exc_code;
      rsp_data_r <= (exc_code == EXC_NONE && !write_r) ? rd_data : WORD_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // Command actions
  // ---------------------------------------------------------------------------
  command_pulser u_command_pulser (
    .i_sys_clk          (i_sys_clk),
    .i_reset            (i_reset),
    .i_cmd_stb          (cmd_stb && (state_r == ST_FETCH)),
    .i_cmd_code         (wdata_r),
    .o_go_auto          (o_go_auto),
    .o_go_manual        (o_go_manual),
    .o_start_autotune   (o_start_autotune),
    .o_clear_alarms     (o_clear_alarms),
    .o_restore_setup    (o_restore_setup),
    .o_restore_programs (o_restore_programs)
  );

endmodule // process_controller_register_map
`default_nettype wire

// *** dv/proc_ctrl_regs_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module proc_ctrl_regs_props
  import proc_ctrl_regs_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic        i_req_fault,
  input wire logic        i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  input wire logic        o_rsp_valid,
  input wire logic        o_rsp_exc,
  input wire logic [7:0]  o_rsp_exc_code,
  input wire logic [15:0] o_loop_one_output,
  input wire logic [15:0] o_display_unit,
  input wire logic        o_go_auto,
  input wire logic        o_start_autotune
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Good request taken, and a write to one address
  sequence s_take;
    i_req_valid && o_req_ready && !i_req_fault;
  endsequence
  sequence s_wr(a);
    s_take ##0 (i_req_write && i_req_addr == a);
  endsequence
  AST_RSP_LAT: assert property (s_take |-> ##2 o_rsp_valid) else $error("answer late");
  AST_BUSY: assert property (s_take |=> !o_req_ready [*2]) else $error("ready while busy");
  AST_DROP: assert property (i_req_valid && o_req_ready && i_req_fault |-> ##2 !o_rsp_valid)
    else $error("faulty request answered");
  AST_BAD_ADDR: assert property (s_take ##0 (i_req_addr == 16'h0FB0)
    |-> ##2 o_rsp_exc && o_rsp_exc_code == EXC_BAD_ADDR) else $error("no address exception");
  AST_RO_WRITE: assert property (s_wr(REG_FIRMWARE_VERSION) |-> ##2 o_rsp_exc_code == EXC_BAD_VALUE)
    else $error("read-only write accepted");
  AST_LOOP_LIMIT: assert property (s_wr(REG_LOOP_ONE_OUTPUT) ##0 (i_req_wdata > LOOP_OUTPUT_MAX)
    |-> ##2 o_rsp_exc && $stable(o_loop_one_output)) else $error("loop limit ignored");
  AST_UNIT_SET: assert property (s_wr(REG_DISPLAY_UNIT) ##0 (i_req_wdata <= DISPLAY_UNIT_MAX)
    |-> ##2 o_display_unit == $past(i_req_wdata, 2)) else $error("unit not stored");
  AST_TUNE_PULSE: assert property ($rose(o_start_autotune) |-> o_rsp_valid ##1 !o_start_autotune)
    else $error("tune pulse wrong");
  AST_CMD_BAD: assert property (s_wr(REG_COMMAND_TRIGGER) ##0 (i_req_wdata > CMD_CODE_MAX)
    |-> ##2 o_rsp_exc && !o_go_auto) else $error("bad command acted");
endmodule // proc_ctrl_regs_props
bind process_controller_register_map proc_ctrl_regs_props u_props (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_fault(i_req_fault), .i_req_write(i_req_write),
  .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .o_rsp_valid(o_rsp_valid), .o_rsp_exc(o_rsp_exc),
  .o_rsp_exc_code(o_rsp_exc_code), .o_loop_one_output(o_loop_one_output), .o_display_unit(o_display_unit),
  .o_go_auto(o_go_auto), .o_start_autotune(o_start_autotune));
`default_nettype wire

// *** dv/float_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module float_src_model
  import proc_ctrl_regs_pkg::*;
(
  input  wire logic [FLOAT_IDX_W-1:0] i_idx,
  output logic [31:0]                 o_value
);
  // Distinct high and low words for each value index
  assign o_value = {10'h300, i_idx, 10'h0C0, i_idx};
endmodule // float_src_model
`default_nettype wire

// *** dv/test_process_controller_register_map.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_process_controller_register_map;
  import proc_ctrl_regs_pkg::*;
  logic        sys_clk, reset, req_valid, req_fault, req_write, got, ex;
  logic [15:0] req_addr, req_wdata, rd, sv[10];
  logic [2:0]  o1t, o2t, opt;
  logic [7:0]  ec;
  logic [5:0]  pc;
  wire         ready, rsp_valid, rsp_exc;
  wire [7:0]   code;
  wire [15:0]  rdata, loop1, loop2, unit, kind;
  wire [5:0]   pul, fidx;
  wire [31:0]  fval;
  int          num_errors = 0, tests_run = 0, cyc = 0;
  process_controller_register_map u_dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_req_valid(req_valid),
    .o_req_ready(ready), .i_req_fault(req_fault), .i_req_write(req_write), .i_req_addr(req_addr),
    .i_req_wdata(req_wdata), .o_rsp_valid(rsp_valid), .o_rsp_exc(rsp_exc), .o_rsp_exc_code(code),
    .o_rsp_data(rdata), .o_float_idx(fidx), .i_float_value(fval), .i_firmware_version(sv[0]),
    .i_out1_type(o1t), .i_out2_type(o2t), .i_option_kind(opt), .i_controller_state(sv[1]),
    .i_alarm_state(sv[2]), .i_error_state(sv[3]), .i_measured_process_value(sv[4]),
    .i_auxiliary_input(sv[5]), .i_setpoint_value(sv[6]), .i_timer_seconds(sv[7]),
    .i_heater_current_on(sv[8]), .i_heater_current_off(sv[9]), .o_loop_one_output(loop1),
    .o_loop_two_output(loop2), .o_display_unit(unit), .o_main_input_kind(kind), .o_go_auto(pul[5]),
    .o_go_manual(pul[4]), .o_start_autotune(pul[3]), .o_clear_alarms(pul[2]),
    .o_restore_setup(pul[1]), .o_restore_programs(pul[0]));
  float_src_model u_src (.i_idx(fidx), .o_value(fval));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task conclude;
    $display("errors=%0d tests=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One register per request, answer captured in its cycle
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic f);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    req_fault <= f;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req_fault <= 1'b0;
    got = 1'b0;
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      if (rsp_valid === 1'b1) begin
        got = 1'b1; rd = rdata; ex = rsp_exc; ec = code; pc = pul;
      end
    end
  endtask
  task automatic rdx(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000, 1'b0);
    chk({got, ex, ec, rd}, {2'b10, EXC_NONE, e});
  endtask
  task automatic wrx(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    acc(1'b1, a, d, 1'b0);
    chk({got, ex, ec, rd}, {1'b1, c != EXC_NONE, c, 16'h0000});
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reads;
    logic [15:0] ra[10] = '{16'h0FA1, 16'h0FA3, 16'h0FA4, 16'h0FA5, 16'h0FA6,
                            16'h0FA7, 16'h0FA8, 16'h0FAB, 16'h0FAC, 16'h0FAD};
    for (int i = 0; i < 10; i++) rdx(ra[i], sv[i]);
    rdx(REG_COMMAND_TRIGGER, WORD_ZERO);
  endtask
  task automatic t_version;
    for (int k = 1; k < 6; k++) begin
      @(posedge sys_clk);
      o1t <= 3'(k); o2t <= 3'(5 - k); opt <= 3'(k);
      rdx(REG_HARDWARE_OPTION, {7'h00, 3'(k), 3'(5 - k), 3'(k)});
    end
  endtask
  task automatic t_settings;
    logic [15:0] wa[8] = '{REG_LOOP_ONE_OUTPUT, REG_LOOP_ONE_OUTPUT, REG_LOOP_TWO_OUTPUT, REG_DISPLAY_UNIT,
                           REG_DISPLAY_UNIT, REG_DISPLAY_UNIT, REG_MAIN_INPUT_KIND, REG_MAIN_INPUT_KIND};
    logic [15:0] wd[8] = '{16'h01F4, 16'h07D0, 16'h03E8, 16'h0001, 16'h0003, 16'h0002, 16'h000E, 16'h000F};
    for (int i = 0; i < 8; i++) wrx(wa[i], wd[i], (i == 1 || i == 4 || i == 7) ? EXC_BAD_VALUE : EXC_NONE);
    chk({loop1, loop2}, {16'h01F4, 16'h03E8});
    chk({unit, kind}, {16'h0002, 16'h000E});
    rdx(REG_LOOP_ONE_OUTPUT, 16'h01F4);
  endtask
  task automatic t_cmds;
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, REG_COMMAND_TRIGGER, 16'(k), 1'b0);
      chk({ex, pc}, (k < 1 || k > 6) ? 7'h40 : {1'b0, 6'(6'h20 >> (k - 1))});
    end
  endtask
  task automatic t_errs;
    rdx(16'h1B5B, 16'h3001);
    rdx(16'h1B58, 16'hC000);
    rdx(16'h1D4E, 16'hC001);
    rdx(16'h1DAF, 16'h3031);
    chk(fidx, 6'h31);
    wrx(16'h1B58, 16'h0001, EXC_BAD_VALUE);
    wrx(16'h1D4C, 16'h0001, EXC_BAD_VALUE);
    wrx(REG_FIRMWARE_VERSION, 16'h0001, EXC_BAD_VALUE);
    wrx(16'h0FB0, 16'h0001, EXC_BAD_ADDR);
    acc(1'b0, REG_MEASURED_MAIN, 16'h0000, 1'b1);
    chk(got, 1'b0);
  endtask
  // Clock, timeout and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    reset = 1'b1; req_valid = 1'b0; req_fault = 1'b0; req_write = 1'b0;
    req_addr = 16'h0000; req_wdata = 16'h0000; o1t = 3'b001; o2t = 3'b010; opt = 3'b011;
    for (int i = 0; i < 10; i++) sv[i] = 16'h1000 + 16'(i * 257);
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reads;
    t_version;
    t_settings;
    t_cmds;
    t_errs;
    conclude;
  end
endmodule // test_process_controller_register_map
`default_nettype wire
